// ### fir_flags.sv
// interrupt flag register and receive status queue behind an ahb-lite slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module fir_flags
	import fir_pkg::*;
#(
	parameter int DEPTH = fir_pkg::FIR_QDEPTH
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata_ff,
	output logic                       hreadyout_ff,
	output logic                       hresp_ff,
	input  wire fir_pkg::fir_evt_t     evt,
	input  wire logic                  send_data_request,
	input  wire logic                  receive_data_request,
	input  wire logic                  frame_len_we,
	input  wire fir_pkg::fir_fstat_t   frame_stat,
	input  wire logic                  frame_last_byte_read,
	input  wire logic                  frame_len_read,
	output logic [FIR_PTRW-1:0]        sts_wr_ptr_ff,
	output logic [FIR_PTRW-1:0]        sts_rd_ptr_ff,
	output logic                       sts_clear_ff,
	output logic                       sts_full_ff,
	output logic                       ir_active_ff
);
	import fir_pkg::*;

	localparam logic [FIR_PTRW:0] CNT_MAX = (FIR_PTRW+1)'(DEPTH);

	// bus state
	fir_bus_t          bus_st_ff;
	fir_bus_t          nxt_bus_st;
	logic [31:0]       req_addr_ff;
	logic [31:0]       nxt_req_addr;
	logic              req_write_ff;
	logic              nxt_req_write;
	logic [31:0]       nxt_hrdata;
	logic              nxt_hreadyout;
	logic              nxt_hresp;
	logic              accept;
	logic              do_rd;
	logic              do_wr;

	// register state
	logic [7:0]        flags_ff;
	logic [7:0]        nxt_flags;
	logic [7:0]        flag_set;

	// control state
	logic [1:0]        mode_ff;
	logic [1:0]        nxt_mode;
	logic              nxt_clear;

	// queue state
	logic [FIR_PTRW-1:0] nxt_wr_ptr;
	logic [FIR_PTRW-1:0] nxt_rd_ptr;
	logic [FIR_PTRW-1:0] vld_ptr_ff;
	logic [FIR_PTRW-1:0] nxt_vld_ptr;
	logic [FIR_PTRW:0]   cnt_ff;
	logic [FIR_PTRW:0]   nxt_cnt;
	logic [FIR_PTRW:0]   vcnt_ff;
	logic [FIR_PTRW:0]   nxt_vcnt;
	logic [DEPTH-1:0]    vld_ff;
	logic [DEPTH-1:0]    nxt_vld;
	logic                rd_seen_ff;
	logic                nxt_rd_seen;
	logic                push;
	logic                mark;
	logic                pop;
	logic                nxt_full;
	logic                nxt_active;
	logic [3:0]          mem_rdata;
	logic [15:0]         sts_view;

	// wrap at the queue depth, not at the pointer width
	function automatic logic [FIR_PTRW-1:0] ptr_inc(input logic [FIR_PTRW-1:0] p);
		logic [FIR_PTRW-1:0] r;
		if (int'(p) == DEPTH - 1) begin
			r = '0;
		end else begin
			r = p + 1'b1;
		end
		return r;
	endfunction

	// status bits of each frame, indexed by the shared pointers
	fir_sts_mem #(
		.W  (4),
		.D  (DEPTH),
		.AW (FIR_PTRW)
	) u_mem (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.we       (push),
		.waddr    (sts_wr_ptr_ff),
		.wdata    (frame_stat),
		.raddr    (nxt_rd_ptr),
		.rdata_ff (mem_rdata)
	);

	// bus slave: one wait state, side effects in the data phase
	// taken only while idle; hready is low in the wait state
	// hsize is ignored; every register is one whole word
	assign accept = hsel && hready && htrans[1];
	assign do_rd  = (bus_st_ff == FIR_BUS_WAIT) && !req_write_ff;
	assign do_wr  = (bus_st_ff == FIR_BUS_WAIT) && req_write_ff;

	always_comb begin
		nxt_bus_st    = bus_st_ff;
		nxt_req_addr  = req_addr_ff;
		nxt_req_write = req_write_ff;
		nxt_hreadyout = 1'b1;
		nxt_hresp     = 1'b0;
		case (bus_st_ff)
			FIR_BUS_IDLE: begin
				if (accept) begin
					nxt_bus_st    = FIR_BUS_WAIT;
					nxt_req_addr  = haddr;
					nxt_req_write = hwrite;
					nxt_hreadyout = 1'b0;
				end
			end
			FIR_BUS_WAIT: begin
				nxt_bus_st = FIR_BUS_IDLE;
			end
			default: begin
				nxt_bus_st = FIR_BUS_IDLE;
			end
		endcase
	end

	// status view: zero outside infrared operation or when empty
	// entries stay queued while stopped; only the view is gated
	always_comb begin
		sts_view = FIR_STS_IDLE;
		if (ir_active_ff && cnt_ff != '0) begin
			sts_view[FIR_STS_VLD] = vld_ff[sts_rd_ptr_ff];
			sts_view[FIR_STS_OVR] = mem_rdata[3];
			sts_view[FIR_STS_CRC] = mem_rdata[2];
			sts_view[FIR_STS_ABT] = mem_rdata[1];
			sts_view[FIR_STS_MAX] = mem_rdata[0];
		end
	end

	// read data holds until the next read completes
	always_comb begin
		nxt_hrdata = hrdata_ff;
		if (do_rd) begin
			nxt_hrdata = '0;
			case (req_addr_ff)
				FIR_ADR_FLAGS: begin
					nxt_hrdata[7:0] = flags_ff;
				end
				FIR_ADR_STATUS: begin
					nxt_hrdata[15:0] = sts_view;
				end
				FIR_ADR_MODE: begin
					nxt_hrdata[1:0] = mode_ff;
				end
				default: begin
					nxt_hrdata = '0;
				end
			endcase
		end
	end

	// mode and clear control
	// a mode write restarts the queue only on a rising enable
	always_comb begin
		nxt_mode  = mode_ff;
		nxt_clear = 1'b0;
		if (do_wr && req_addr_ff == FIR_ADR_MODE) begin
			nxt_mode = hwdata[1:0];
			if (hwdata[FIR_MODE_EN] && !mode_ff[FIR_MODE_EN]) begin
				nxt_clear = 1'b1;
			end
		end
		if (do_wr && req_addr_ff == FIR_ADR_CLEAR && hwdata[FIR_CLR_RECEIVE_STATUS_ENTRY]) begin
			nxt_clear = 1'b1;
		end
		nxt_active = nxt_mode[FIR_MODE_IR] && nxt_mode[FIR_MODE_EN];
	end

	// interrupt flags: set wins over read clear
	always_comb begin
		flag_set                = '0;
		flag_set[FIR_FLG_ABORT] = evt.tx_abort;
		flag_set[FIR_FLG_ERR]   = evt.tx_err;
		flag_set[FIR_FLG_VALID] = mark;
		flag_set[FIR_FLG_DMA]   = evt.dma_end;
		flag_set[FIR_FLG_RXEND] = evt.rx_stop;
		flag_set[FIR_FLG_TXEND] = evt.tx_stop;
		nxt_flags = flags_ff;
		if (do_rd && req_addr_ff == FIR_ADR_FLAGS) begin
			nxt_flags = flags_ff & ~FIR_FLG_STICKY;
		end
		nxt_flags = nxt_flags | (flag_set & FIR_FLG_STICKY);
		// bits 1 and 0 follow the request lines, no read clear
		nxt_flags[FIR_FLG_WRRQ] = send_data_request;
		nxt_flags[FIR_FLG_RDRQ] = receive_data_request;
	end

	// status queue pointers and valid marks
	// a push while full is dropped without notice
	// marks run from the oldest unmarked entry
	assign push = frame_len_we && cnt_ff != CNT_MAX && !sts_clear_ff;
	assign mark = frame_last_byte_read && vcnt_ff != cnt_ff && !sts_clear_ff;
	assign pop  = frame_len_read && rd_seen_ff && vcnt_ff != '0;

	always_comb begin
		nxt_wr_ptr  = sts_wr_ptr_ff;
		nxt_rd_ptr  = sts_rd_ptr_ff;
		nxt_vld_ptr = vld_ptr_ff;
		nxt_cnt     = cnt_ff;
		nxt_vcnt    = vcnt_ff;
		nxt_vld     = vld_ff;
		nxt_rd_seen = rd_seen_ff;
		if (do_rd && req_addr_ff == FIR_ADR_STATUS) begin
			nxt_rd_seen = sts_view[FIR_STS_VLD];
		end
		if (push) begin
			nxt_wr_ptr = ptr_inc(sts_wr_ptr_ff);
			nxt_vld[sts_wr_ptr_ff] = 1'b0;
		end
		if (mark) begin
			nxt_vld[vld_ptr_ff] = 1'b1;
			nxt_vld_ptr = ptr_inc(vld_ptr_ff);
		end
		if (pop) begin
			nxt_rd_ptr = ptr_inc(sts_rd_ptr_ff);
			nxt_vld[sts_rd_ptr_ff] = 1'b0;
			nxt_rd_seen = 1'b0;
		end
		nxt_cnt  = cnt_ff + (FIR_PTRW+1)'(push) - (FIR_PTRW+1)'(pop);
		nxt_vcnt = vcnt_ff + (FIR_PTRW+1)'(mark) - (FIR_PTRW+1)'(pop);
		// a clear overrides every move in the same cycle
		if (sts_clear_ff) begin
			nxt_wr_ptr  = '0;
			nxt_rd_ptr  = '0;
			nxt_vld_ptr = '0;
			nxt_cnt     = '0;
			nxt_vcnt    = '0;
			nxt_vld     = '0;
			nxt_rd_seen = 1'b0;
		end
		nxt_full = nxt_cnt == CNT_MAX;
	end

	// bus and read data registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_st_ff     <= FIR_BUS_IDLE;
			req_addr_ff   <= '0;
			req_write_ff  <= 1'b0;
			hrdata_ff     <= '0;
			hreadyout_ff  <= 1'b1;
			hresp_ff      <= 1'b0;
		end else begin
			bus_st_ff     <= nxt_bus_st;
			req_addr_ff   <= nxt_req_addr;
			req_write_ff  <= nxt_req_write;
			hrdata_ff     <= nxt_hrdata;
			hreadyout_ff  <= nxt_hreadyout;
			hresp_ff      <= nxt_hresp;
		end
	end

	// flag register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff      <= FIR_FLAGS_RST;
		end else begin
			flags_ff      <= nxt_flags;
		end
	end

	// mode and clear registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff       <= FIR_MODE_RST;
			sts_clear_ff  <= 1'b0;
			ir_active_ff  <= 1'b0;
		end else begin
			mode_ff       <= nxt_mode;
			sts_clear_ff  <= nxt_clear;
			ir_active_ff  <= nxt_active;
		end
	end

	// queue registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sts_wr_ptr_ff <= '0;
			sts_rd_ptr_ff <= '0;
			vld_ptr_ff    <= '0;
			cnt_ff        <= '0;
			vcnt_ff       <= '0;
			vld_ff        <= '0;
			rd_seen_ff    <= 1'b0;
			sts_full_ff   <= 1'b0;
		end else begin
			sts_wr_ptr_ff <= nxt_wr_ptr;
			sts_rd_ptr_ff <= nxt_rd_ptr;
			vld_ptr_ff    <= nxt_vld_ptr;
			cnt_ff        <= nxt_cnt;
			vcnt_ff       <= nxt_vcnt;
			vld_ff        <= nxt_vld;
			rd_seen_ff    <= nxt_rd_seen;
			sts_full_ff   <= nxt_full;
		end
	end
endmodule

// ### fir_pkg.sv
// constants and types for the infrared flag and receive status bank
package fir_pkg;
	localparam int          FIR_DW          = 32;
	localparam int          FIR_QDEPTH      = 7;
	localparam int          FIR_PTRW        = 3;
	// register indices; byte address is four times the index
	localparam logic [31:0] FIR_IDX_FLAGS   = 32'h0c00006a;
	localparam logic [31:0] FIR_IDX_STATUS  = 32'h0c00006c;
	localparam logic [31:0] FIR_IDX_CLEAR   = 32'h0c000080;
	localparam logic [31:0] FIR_IDX_MODE    = 32'h0c000082;
	localparam logic [31:0] FIR_ADR_FLAGS   = FIR_IDX_FLAGS << 2;
	localparam logic [31:0] FIR_ADR_STATUS  = FIR_IDX_STATUS << 2;
	localparam logic [31:0] FIR_ADR_CLEAR   = FIR_IDX_CLEAR << 2;
	localparam logic [31:0] FIR_ADR_MODE    = FIR_IDX_MODE << 2;
	// interrupt_flags bit positions
	localparam int          FIR_FLG_ABORT   = 7;
	localparam int          FIR_FLG_ERR     = 6;
	localparam int          FIR_FLG_VALID   = 5;
	localparam int          FIR_FLG_DMA     = 4;
	localparam int          FIR_FLG_RXEND   = 3;
	localparam int          FIR_FLG_TXEND   = 2;
	localparam int          FIR_FLG_WRRQ    = 1;
	localparam int          FIR_FLG_RDRQ    = 0;
	localparam logic [7:0]  FIR_FLG_STICKY  = 8'hfc;
	localparam logic [7:0]  FIR_FLAGS_RST   = 8'h00;
	// receive_status_entry bit positions
	localparam int          FIR_STS_VLD     = 7;
	localparam int          FIR_STS_OVR     = 4;
	localparam int          FIR_STS_CRC     = 3;
	localparam int          FIR_STS_ABT     = 2;
	localparam int          FIR_STS_MAX     = 1;
	localparam logic [15:0] FIR_STS_IDLE    = 16'h0000;
	// fifo_clear_control and mode bits
	localparam int          FIR_CLR_RECEIVE_STATUS_ENTRY   = 1;
	localparam int          FIR_MODE_IR     = 0;
	localparam int          FIR_MODE_EN     = 1;
	localparam logic [1:0]  FIR_MODE_RST    = 2'h0;

	typedef struct packed {
		logic tx_abort;
		logic tx_err;
		logic dma_end;
		logic rx_stop;
		logic tx_stop;
	} fir_evt_t;

	typedef struct packed {
		logic fifo_overrun;
		logic crc_err;
		logic abort;
		logic max_size_overrun;
	} fir_fstat_t;

	typedef enum logic [1:0] {
		FIR_BUS_IDLE = 2'b00,
		FIR_BUS_WAIT = 2'b01
	} fir_bus_t;
endpackage

// ### fir_sts_mem.sv
// small status memory with registered read data
`timescale 1ns/1ps
module fir_sts_mem #(
	parameter int W = 4,
	parameter int D = 7,
	parameter int AW = 3
) (
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_ff
);
	logic [W-1:0] mem_ff [D];
	logic [W-1:0] nxt_rdata;

	always_comb begin
		nxt_rdata = '0;
		if (int'(raddr) < D) begin
			nxt_rdata = mem_ff[raddr];
		end
		// write-through so a head written this cycle is not stale
		if (we && waddr == raddr) begin
			nxt_rdata = wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (we && int'(waddr) < D) begin
			mem_ff[waddr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end
endmodule

// ### fir_flags_sva.sv
// assertion checker for the flag and receive status bank
`timescale 1ns/1ps
module fir_flags_sva
	import fir_pkg::*;
#(
	parameter int DEPTH = FIR_QDEPTH
) (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata_ff,
	input wire logic        hreadyout_ff,
	input wire logic        hresp_ff,
	input wire logic        frame_len_we,
	input wire logic        frame_len_read,
	input wire logic [2:0]  sts_wr_ptr_ff,
	input wire logic [2:0]  sts_rd_ptr_ff,
	input wire logic        sts_clear_ff,
	input wire logic        sts_full_ff,
	input wire logic        ir_active_ff
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic tk = hsel && hready && htrans[1] && hreadyout_ff;
	resp_okay_a: assert property (!hresp_ff) else $error("error response");
	wait_one_a: assert property (tk |=> !hreadyout_ff ##1 hreadyout_ff) else $error("wait state not one cycle");
	push_ptr_a: assert property (frame_len_we && !sts_full_ff && !sts_clear_ff |=> sts_wr_ptr_ff ==
		($past(sts_wr_ptr_ff) == 3'(DEPTH - 1) ? 3'h0 : $past(sts_wr_ptr_ff) + 3'h1)) else $error("push slip");
	full_drop_a: assert property (frame_len_we && sts_full_ff && !sts_clear_ff |=> $stable(sts_wr_ptr_ff))
		else $error("push taken while full");
	full_eq_a: assert property (sts_full_ff |-> sts_wr_ptr_ff == sts_rd_ptr_ff) else $error("full with gap");
	clear_ptr_a: assert property (sts_clear_ff |=> sts_wr_ptr_ff == 3'h0 && sts_rd_ptr_ff == 3'h0 && !sts_full_ff)
		else $error("clear left entries");
	clear_wr_a: assert property (tk && hwrite && haddr == FIR_ADR_CLEAR ##1 hwdata[FIR_CLR_RECEIVE_STATUS_ENTRY] |=> sts_clear_ff)
		else $error("clear write ignored");
	rd_move_a: assert property (!$stable(sts_rd_ptr_ff) |-> $past(frame_len_read) || sts_rd_ptr_ff == 3'h0)
		else $error("read pointer moved alone");
	wr_move_a: assert property (!$stable(sts_wr_ptr_ff) |-> $past(frame_len_we) || sts_wr_ptr_ff == 3'h0)
		else $error("write pointer moved alone");
	off_zero_a: assert property (tk && !hwrite && haddr == FIR_ADR_STATUS && !ir_active_ff ##1 !ir_active_ff
		|=> hrdata_ff == 32'h0) else $error("status nonzero while stopped");
	upper_zero_a: assert property ($rose(hreadyout_ff) |-> hrdata_ff[31:8] == 24'h0) else $error("upper bits set");
	cover property (sts_full_ff);
	cover property (sts_clear_ff);
	cover property (!$stable(sts_rd_ptr_ff));
endmodule

bind fir_flags fir_flags_sva #(.DEPTH(DEPTH)) u_sva (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata_ff, .hreadyout_ff, .hresp_ff, .frame_len_we, .frame_len_read, .sts_wr_ptr_ff, .sts_rd_ptr_ff,
	.sts_clear_ff, .sts_full_ff, .ir_active_ff);

// ### fir_tb.sv
// self-checking testbench for the flag and receive status bank
`timescale 1ns/1ps
module testbench;
	import fir_pkg::*;
	logic        ref_clk, rst_n, hsel, hwrite, hreadyout_ff, hresp_ff, sts_clear_ff, sts_full_ff, ir_active_ff;
	logic        send_data_request, receive_data_request, frame_len_we, frame_last_byte_read, frame_len_read;
	logic [31:0] haddr, hwdata, hrdata_ff;
	logic [1:0]  htrans;
	logic [2:0]  sts_wr_ptr_ff, sts_rd_ptr_ff;
	fir_evt_t    evt;
	fir_fstat_t  frame_stat;
	int          fails, n_checks, n_clr;

	fir_flags dut (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout_ff),
		.hrdata_ff, .hreadyout_ff, .hresp_ff, .evt, .send_data_request, .receive_data_request, .frame_len_we,
		.frame_stat, .frame_last_byte_read, .frame_len_read, .sts_wr_ptr_ff, .sts_rd_ptr_ff, .sts_clear_ff,
		.sts_full_ff, .ir_active_ff);

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (hreadyout_ff !== 1'b1 && k < 20);
		if (hreadyout_ff !== 1'b1) begin
			fails++;
		end
	endtask
	task automatic bus(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata_ff;
		chk({31'h0, hresp_ff}, 32'h0);
	endtask
	task automatic rdc(logic [31:0] a, logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask
	task automatic wrr(logic [31:0] a, logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic tick(fir_evt_t e, logic we, fir_fstat_t st, logic lb, logic lr);
		evt <= e;
		frame_len_we <= we;
		frame_stat <= st;
		frame_last_byte_read <= lb;
		frame_len_read <= lr;
		@(posedge ref_clk);
		evt <= '0;
		frame_len_we <= 1'b0;
		frame_last_byte_read <= 1'b0;
		frame_len_read <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic pc(logic [2:0] wp, logic [2:0] rp, logic full);
		@(negedge ref_clk);
		chk({29'h0, sts_wr_ptr_ff}, {29'h0, wp});
		chk({29'h0, sts_rd_ptr_ff}, {29'h0, rp});
		chk({31'h0, sts_full_ff}, {31'h0, full});
		@(posedge ref_clk);
	endtask

	task automatic act(logic a, int c);
		@(negedge ref_clk);
		chk({31'h0, ir_active_ff}, {31'h0, a});
		chk(n_clr, c);
		@(posedge ref_clk);
	endtask
	always @(negedge ref_clk) begin
		if (sts_clear_ff === 1'b1) begin
			n_clr++;
		end
	end

	task automatic t_reset();
		rdc(FIR_ADR_FLAGS, 32'h0);
		rdc(FIR_ADR_STATUS, 32'h0);
		wrr(FIR_ADR_FLAGS, 32'h000000ff);
		rdc(FIR_ADR_FLAGS, 32'h0);
		rdc(32'h0, 32'h0);
	endtask
	task automatic t_flags();
		logic [31:0] fb[5] = '{32'h04, 32'h08, 32'h10, 32'h40, 32'h80};
		for (int i = 0; i < 5; i++) begin
			tick(fir_evt_t'(5'h1 << i), 1'b0, '0, 1'b0, 1'b0);
			rdc(FIR_ADR_FLAGS, fb[i]);
			rdc(FIR_ADR_FLAGS, 32'h0);
		end
		send_data_request <= 1'b1;
		receive_data_request <= 1'b1;
		@(posedge ref_clk);
		rdc(FIR_ADR_FLAGS, 32'h3);
		rdc(FIR_ADR_FLAGS, 32'h3);
		send_data_request <= 1'b0;
		receive_data_request <= 1'b0;
		@(posedge ref_clk);
		rdc(FIR_ADR_FLAGS, 32'h0);
	endtask
	task automatic t_queue();
		wrr(FIR_ADR_MODE, 32'h3);
		act(1'b1, 1);
		tick('0, 1'b1, 4'ha, 1'b0, 1'b0);
		tick('0, 1'b1, 4'h5, 1'b0, 1'b0);
		rdc(FIR_ADR_STATUS, 32'h14);
		tick('0, 1'b0, '0, 1'b0, 1'b1);
		pc(3'h2, 3'h0, 1'b0);
		tick('0, 1'b0, '0, 1'b1, 1'b0);
		rdc(FIR_ADR_FLAGS, 32'h20);
		rdc(FIR_ADR_STATUS, 32'h94);
		tick('0, 1'b0, '0, 1'b0, 1'b1);
		pc(3'h2, 3'h1, 1'b0);
		tick('0, 1'b0, '0, 1'b1, 1'b0);
		rdc(FIR_ADR_STATUS, 32'h8a);
	endtask
	task automatic t_full();
		tick('0, 1'b0, '0, 1'b0, 1'b1);
		repeat (7) tick('0, 1'b1, '0, 1'b0, 1'b0);
		pc(3'h2, 3'h2, 1'b1);
		tick('0, 1'b1, '0, 1'b1, 1'b0);
		pc(3'h2, 3'h2, 1'b1);
		wrr(FIR_ADR_MODE, 32'h0);
		rdc(FIR_ADR_STATUS, 32'h0);
		act(1'b0, 1);
		wrr(FIR_ADR_MODE, 32'h1);
		rdc(FIR_ADR_STATUS, 32'h0);
		wrr(FIR_ADR_MODE, 32'h3);
		rdc(FIR_ADR_STATUS, 32'h0);
		act(1'b1, 2);
		pc(3'h0, 3'h0, 1'b0);
		tick('0, 1'b1, 4'hf, 1'b0, 1'b0);
		tick('0, 1'b0, '0, 1'b1, 1'b0);
		wrr(FIR_ADR_MODE, 32'h2);
		rdc(FIR_ADR_STATUS, 32'h0);
		wrr(FIR_ADR_MODE, 32'h3);
		rdc(FIR_ADR_STATUS, 32'h9e);
		act(1'b1, 2);
		wrr(FIR_ADR_CLEAR, 32'h2);
		act(1'b1, 3);
		rdc(FIR_ADR_STATUS, 32'h0);
		pc(3'h0, 3'h0, 1'b0);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#50us;
		fails++;
		wrap_up();
	end
	initial begin
		{rst_n, hsel, hwrite, send_data_request, receive_data_request} = '0;
		{frame_len_we, frame_last_byte_read, frame_len_read, haddr, hwdata, htrans} = '0;
		evt = '0;
		frame_stat = '0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_flags();
		t_queue();
		t_full();
		wrap_up();
	end
endmodule
